// *** itu_irq_and_timer_unit.sv ***
// Module: event flags, enables, interrupt pin and five down-counters
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module itu_irq_and_timer_unit #(
   parameter int FIFO_DEPTH = 512,
   parameter int LEVEL_W = 10
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Avalon-MM slave
   input wire itu_pkg::itu_av_req_t av_req,
   output logic [31:0] av_readdata,
   output logic av_waitrequest,
   // Event sources, same clock
   input wire itu_pkg::itu_events_t events,
   input wire logic [LEVEL_W-1:0] fifo_level,
   input wire logic [3:0] stop_event,
   // Count clocks from other domains
   input wire logic count_clk_fast,
   input wire logic count_clk_mid,
   input wire logic slow_oscillator,
   // Interrupt request pin
   output logic irq_req
);
   import itu_pkg::*;

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   generate
      if (FIFO_DEPTH < 2 || FIFO_DEPTH > 1023 ||
          LEVEL_W != $clog2(FIFO_DEPTH + 1) || LEVEL_W < 9) begin : g_bad
         $error("itu_irq_and_timer_unit: bad FIFO_DEPTH or LEVEL_W");
      end
   endgenerate

   localparam logic [LEVEL_W-1:0] DEPTH_V = LEVEL_W'(FIFO_DEPTH);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [6:0] flags_a;
      logic [6:0] flags_b;
      logic [6:0] enable_a;
      logic [6:0] enable_b;
      logic pin_en;
      logic [8:0] threshold;
      logic [4:0][15:0] value;
      logic [4:0][15:0] reload;
      logic [4:0] running;
      logic [4:0] auto_reload;
      logic [3:0] stop_en;
      logic [3:0][1:0] clk_sel;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] sync_prev;
      logic high_prev;
      logic low_prev;
      logic ack;
      logic [31:0] rdata;
      logic irq;
   } itu_state_t;

   itu_state_t st;
   itu_state_t next_st;

   logic [2:0] edges;
   logic [4:0] tick;
   logic [4:0] underflow;
   logic wake_uf;
   logic high_status;
   logic low_status;
   logic [LEVEL_W-1:0] thr_ext;
   logic [31:0] rd;
   logic wr_go;
   logic [2:0] bank;
   logic [2:0] idx;
   logic [4:0] sub;
   logic [7:0] wd;
   logic [6:0] pend_a;
   logic [6:0] pend_b;

   assign av_readdata = st.rdata;
   assign av_waitrequest = (av_req.read | av_req.write) & ~st.ack;
   assign irq_req = st.irq;

   // Set bits 0-6 when bit 7 is one, else clear them
   function automatic logic [6:0] setclr(input logic [6:0] cur,
                                         input logic [7:0] w);
      if (w[ITU_SETCLR_BIT]) begin
         setclr = cur | w[6:0];
      end else begin
         setclr = cur & ~w[6:0];
      end
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      rd = 32'h0000_0000;
      wr_go = av_req.write & st.ack & av_req.byteenable[0];
      bank = av_req.address[7:5];
      idx = bank - ITU_CNT_BANK_FIRST;
      sub = av_req.address[4:0];
      wd = av_req.writedata[7:0];

      // Pending flags, read by the status bit and the summary flag
      pend_a = st.flags_a & st.enable_a;
      pend_b = st.flags_b & st.enable_b;

      // ---------------------------------------------------------------
      // Count clock synchronisers and rising edges
      // ---------------------------------------------------------------
      // Only the second stage feeds the edge detector
      next_st.sync1 = {slow_oscillator, count_clk_mid, count_clk_fast};
      next_st.sync2 = st.sync1;
      next_st.sync_prev = st.sync2;
      edges = st.sync2 & ~st.sync_prev;

      // ---------------------------------------------------------------
      // Wakeup counter always counts the slow oscillator
      // ---------------------------------------------------------------
      tick[4] = edges[2];
      wake_uf = st.running[4] & edges[2] & (st.value[4] == 16'h0000);
      for (int i = 0; i < 4; i++) begin
         unique case (st.clk_sel[i])
            ITU_SEL_FAST: tick[i] = edges[0];
            ITU_SEL_MID: tick[i] = edges[1];
            ITU_SEL_WAKEUP: tick[i] = wake_uf;
            default: tick[i] = 1'b0;
         endcase
      end

      // ---------------------------------------------------------------
      // Counters
      // ---------------------------------------------------------------
      // A stop event wins over a tick, so no flag follows it
      for (int i = 0; i < 5; i++) begin
         underflow[i] = 1'b0;
         if (st.running[i]) begin
            if (i < 4 && st.stop_en[i & 3] && stop_event[i & 3]) begin
               next_st.running[i] = 1'b0;
            end else if (tick[i]) begin
               if (st.value[i] == 16'h0000) begin
                  underflow[i] = 1'b1;
                  if (st.auto_reload[i]) begin
                     next_st.value[i] = st.reload[i];
                  end else begin
                     next_st.running[i] = 1'b0;
                  end
               end else begin
                  next_st.value[i] = st.value[i] - 16'h0001;
               end
            end
         end
      end

      // ---------------------------------------------------------------
      // Register read, latched on the first cycle of a request
      // ---------------------------------------------------------------
      // Reserved and unmapped bits read as zero
      unique case (av_req.address)
         ITU_PRIMARY_STATUS_REG: begin
            rd[ITU_STAT_IND_BIT] = st.irq | (|pend_a) | (|pend_b);
            rd[ITU_STAT_PIN_EN_BIT] = st.pin_en;
         end
         ITU_EVENT_FLAGS_A: rd[6:0] = st.flags_a;
         ITU_EVENT_FLAGS_B: rd[6:0] = st.flags_b;
         ITU_EVENT_ENABLE_A: rd[6:0] = st.enable_a;
         ITU_EVENT_ENABLE_B: rd[6:0] = st.enable_b;
         ITU_FIFO_THRESHOLD: rd[7:0] = st.threshold[7:0];
         ITU_FIFO_THRESHOLD_MSB: rd[0] = st.threshold[8];
         ITU_COUNTER_GROUP_CONTROL: rd[3:0] = st.running[3:0];
         default: begin
            if (bank >= ITU_CNT_BANK_FIRST && idx < 3'h5) begin
               unique case (sub)
                  ITU_CNT_CONTROL: begin
                     if (idx == 3'h4) begin
                        rd[ITU_WAKE_RUN_BIT] = st.running[4];
                        rd[ITU_WAKE_AUTO_BIT] = st.auto_reload[4];
                     end else begin
                        rd[1:0] = st.clk_sel[idx[1:0]];
                        rd[ITU_CTL_AUTO_BIT] = st.auto_reload[idx];
                        rd[ITU_CTL_STOP_EN_BIT] = st.stop_en[idx[1:0]];
                     end
                  end
                  ITU_CNT_RELOAD_HIGH: rd[7:0] = st.reload[idx][15:8];
                  ITU_CNT_RELOAD_LOW: rd[7:0] = st.reload[idx][7:0];
                  ITU_CNT_VALUE_HIGH: rd[7:0] = st.value[idx][15:8];
                  ITU_CNT_VALUE_LOW: rd[7:0] = st.value[idx][7:0];
                  default: rd = 32'h0000_0000;
               endcase
            end
         end
      endcase
      next_st.ack = (av_req.read | av_req.write) & ~st.ack;
      if (av_req.read & ~st.ack) begin
         next_st.rdata = rd;
      end

      // ---------------------------------------------------------------
      // Register write, taken at the edge where waitrequest is low
      // ---------------------------------------------------------------
      if (wr_go) begin
         unique case (av_req.address)
            ITU_PRIMARY_STATUS_REG: next_st.pin_en = wd[ITU_STAT_PIN_EN_BIT];
            ITU_EVENT_FLAGS_A: next_st.flags_a = setclr(st.flags_a, wd);
            ITU_EVENT_FLAGS_B: next_st.flags_b = setclr(st.flags_b, wd);
            ITU_EVENT_ENABLE_A: next_st.enable_a = setclr(st.enable_a, wd);
            ITU_EVENT_ENABLE_B: next_st.enable_b = setclr(st.enable_b, wd);
            ITU_FIFO_THRESHOLD: next_st.threshold[7:0] = wd;
            ITU_FIFO_THRESHOLD_MSB: next_st.threshold[8] = wd[0];
            ITU_COUNTER_GROUP_CONTROL: begin
               for (int i = 0; i < 4; i++) begin
                  if (wd[ITU_STROBE_LSB + i]) begin
                     next_st.running[i] = wd[i];
                     if (wd[i]) begin
                        next_st.value[i] = st.reload[i];
                     end
                  end
               end
            end
            default: begin
               if (bank >= ITU_CNT_BANK_FIRST && idx < 3'h5) begin
                  unique case (sub)
                     ITU_CNT_CONTROL: begin
                        if (idx == 3'h4) begin
                           next_st.running[4] = wd[ITU_WAKE_RUN_BIT];
                           next_st.auto_reload[4] = wd[ITU_WAKE_AUTO_BIT];
                           if (wd[ITU_WAKE_RUN_BIT] & ~st.running[4]) begin
                              next_st.value[4] = st.reload[4];
                           end
                        end else begin
                           next_st.clk_sel[idx[1:0]] = wd[1:0];
                           next_st.auto_reload[idx] = wd[ITU_CTL_AUTO_BIT];
                           next_st.stop_en[idx[1:0]] = wd[ITU_CTL_STOP_EN_BIT];
                        end
                     end
                     ITU_CNT_RELOAD_HIGH: next_st.reload[idx][15:8] = wd;
                     ITU_CNT_RELOAD_LOW: next_st.reload[idx][7:0] = wd;
                     default: begin
                     end
                  endcase
               end
            end
         endcase
      end

      // ---------------------------------------------------------------
      // FIFO warning levels from one threshold
      // ---------------------------------------------------------------
      thr_ext = LEVEL_W'(st.threshold);
      high_status = fifo_level >= (DEPTH_V - thr_ext);
      low_status = fifo_level <= thr_ext;
      next_st.high_prev = high_status;
      next_st.low_prev = low_status;

      // ---------------------------------------------------------------
      // Hardware sets, applied after the host write so a set wins
      // ---------------------------------------------------------------
      // Error flag re-sets each cycle while an error bit stands
      if (events.send_done) next_st.flags_a[ITU_A_SEND_DONE] = 1'b1;
      if (events.receive_done) next_st.flags_a[ITU_A_RECEIVE_DONE] = 1'b1;
      if (events.command_done) next_st.flags_a[ITU_A_COMMAND_DONE] = 1'b1;
      if (high_status & ~st.high_prev) next_st.flags_a[ITU_A_FIFO_HIGH] = 1'b1;
      if (low_status & ~st.low_prev) next_st.flags_a[ITU_A_FIFO_LOW] = 1'b1;
      if (|events.rx_error_bits) next_st.flags_a[ITU_A_COMM_ERROR] = 1'b1;
      if (events.card_detect) next_st.flags_a[ITU_A_CARD_DETECT] = 1'b1;
      if (events.frame_start) next_st.flags_b[ITU_B_FRAME_START] = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (underflow[i]) next_st.flags_b[i] = 1'b1;
      end
      if (underflow[4]) next_st.flags_b[ITU_B_WAKEUP] = 1'b1;

      // ---------------------------------------------------------------
      // Summary flag over every other enabled pending flag
      // ---------------------------------------------------------------
      if ((|pend_a) | (|pend_b[5:0])) begin
         next_st.flags_b[ITU_B_ANY_EVENT] = 1'b1;
      end

      // ---------------------------------------------------------------
      // Pin follows pending flags of the new state
      // ---------------------------------------------------------------
      // Rises at the same edge as the flag behind it
      next_st.irq = next_st.pin_en &
         ((|(next_st.flags_a & next_st.enable_a)) |
          (|(next_st.flags_b & next_st.enable_b)));
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Reset acts whatever the clock enable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= '0;
         st.flags_a <= ITU_FLAGS_RST;
         st.flags_b <= ITU_FLAGS_RST;
         st.enable_a <= ITU_ENABLE_RST;
         st.enable_b <= ITU_ENABLE_RST;
         st.pin_en <= ITU_PIN_EN_RST;
         st.threshold <= ITU_THRESHOLD_RST;
         st.reload <= {5{ITU_RELOAD_RST}};
      end else if (clk_en) begin
         st <= next_st;
      end
   end

endmodule // itu_irq_and_timer_unit

`default_nettype wire

// *** itu_pkg.sv ***
// Package: register map, field layout and carrier types of the event/counter unit
`default_nettype none

package itu_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ITU_PRIMARY_STATUS_REG = 8'h00;
   localparam logic [7:0] ITU_EVENT_FLAGS_A = 8'h04;
   localparam logic [7:0] ITU_EVENT_FLAGS_B = 8'h08;
   localparam logic [7:0] ITU_EVENT_ENABLE_A = 8'h0C;
   localparam logic [7:0] ITU_EVENT_ENABLE_B = 8'h10;
   localparam logic [7:0] ITU_FIFO_THRESHOLD = 8'h14;
   localparam logic [7:0] ITU_FIFO_THRESHOLD_MSB = 8'h18;
   localparam logic [7:0] ITU_COUNTER_GROUP_CONTROL = 8'h1C;
   // Counter n sits at (n + 1) * 0x20; wakeup counter is n = 4
   localparam logic [2:0] ITU_CNT_BANK_FIRST = 3'h1;
   localparam logic [4:0] ITU_CNT_CONTROL = 5'h00;
   localparam logic [4:0] ITU_CNT_RELOAD_HIGH = 5'h04;
   localparam logic [4:0] ITU_CNT_RELOAD_LOW = 5'h08;
   localparam logic [4:0] ITU_CNT_VALUE_HIGH = 5'h0C;
   localparam logic [4:0] ITU_CNT_VALUE_LOW = 5'h10;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int ITU_SETCLR_BIT = 7;
   localparam int ITU_STAT_IND_BIT = 0;
   localparam int ITU_STAT_PIN_EN_BIT = 1;
   localparam int ITU_STROBE_LSB = 4;
   localparam int ITU_CTL_AUTO_BIT = 2;
   localparam int ITU_CTL_STOP_EN_BIT = 3;
   localparam int ITU_WAKE_RUN_BIT = 0;
   localparam int ITU_WAKE_AUTO_BIT = 1;
   // Flag bank A
   localparam int ITU_A_SEND_DONE = 0;
   localparam int ITU_A_RECEIVE_DONE = 1;
   localparam int ITU_A_COMMAND_DONE = 2;
   localparam int ITU_A_FIFO_HIGH = 3;
   localparam int ITU_A_FIFO_LOW = 4;
   localparam int ITU_A_COMM_ERROR = 5;
   localparam int ITU_A_CARD_DETECT = 6;
   // Flag bank B: bits 0..3 are the four counters
   localparam int ITU_B_FRAME_START = 4;
   localparam int ITU_B_WAKEUP = 5;
   localparam int ITU_B_ANY_EVENT = 6;

   // ---------------------------------------------------------------
   // Reset values and encodings
   // ---------------------------------------------------------------
   localparam logic [6:0] ITU_FLAGS_RST = 7'h00;
   localparam logic [6:0] ITU_ENABLE_RST = 7'h00;
   localparam logic ITU_PIN_EN_RST = 1'b1;
   localparam logic [8:0] ITU_THRESHOLD_RST = 9'h008;
   localparam logic [15:0] ITU_RELOAD_RST = 16'h0000;
   localparam logic [1:0] ITU_SEL_FAST = 2'h0;
   localparam logic [1:0] ITU_SEL_MID = 2'h1;
   localparam logic [1:0] ITU_SEL_WAKEUP = 2'h2;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } itu_av_req_t;

   typedef struct packed {
      logic send_done;
      logic receive_done;
      logic command_done;
      logic card_detect;
      logic frame_start;
      logic [7:0] rx_error_bits;
   } itu_events_t;

endpackage : itu_pkg

`default_nettype wire

// *** itu_host_model.sv ***
// Host model: Avalon-MM master that drives the register bus
`timescale 1ns/1ps
`default_nettype none

module itu_host_model (
   // Bus clock
   input wire logic sys_clk,
   // Avalon-MM master side
   output var itu_pkg::itu_av_req_t av_req,
   input wire logic [31:0] av_readdata,
   input wire logic av_waitrequest
);
   import itu_pkg::*;
   logic [31:0] sink;
   initial av_req = '0;
   // Request held until waitrequest is seen low at a rising edge
   task automatic xfer(input logic wr_en, input logic [7:0] a,
                       input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      av_req <= '{read: !wr_en, write: wr_en, address: a,
                  byteenable: be, writedata: {24'h000000, d}};
      @(posedge sys_clk);
      while (av_waitrequest && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      if (av_waitrequest)
         test_irq_and_timer_unit.fail_wait();
      q = av_readdata;
      av_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, 4'hF, sink);
   endtask
   task automatic wr_lanes(input logic [7:0] a, input logic [7:0] d,
                           input logic [3:0] be);
      xfer(1'b1, a, d, be, sink);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 8'h00, 4'hF, q);
   endtask
   // Run bit plus strobe starts, strobe alone stops
   task automatic start(input int n);
      wr(ITU_COUNTER_GROUP_CONTROL, 8'h11 << n);
   endtask
   task automatic stop(input int n);
      wr(ITU_COUNTER_GROUP_CONTROL, 8'h10 << n);
   endtask
endmodule // itu_host_model

`default_nettype wire

// *** itu_irq_and_timer_unit_properties.sv ***
// Checker: bus timing, readback and interrupt pin properties
`timescale 1ns/1ps
`default_nettype none

module itu_irq_and_timer_unit_checker #(
   parameter int FIFO_DEPTH = 512,
   parameter int LEVEL_W = 10
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Register bus
   input wire itu_pkg::itu_av_req_t av_req,
   input wire logic [31:0] av_readdata,
   input wire logic av_waitrequest,
   // Interrupt pin
   input wire logic irq_req
);
   import itu_pkg::*;
   logic rd_done;
   logic wr_done;
   assign rd_done = av_req.read && !av_waitrequest;
   assign wr_done = av_req.write && !av_waitrequest;
   sequence s_taken;
      (av_req.read || av_req.write) && av_waitrequest && clk_en;
   endsequence
   sequence s_answer;
      !av_waitrequest;
   endsequence
   a_one_wait: assert property (@(posedge sys_clk) disable iff (rst)
      s_taken |=> s_answer) else $error("bus answer late");
   a_idle_ready: assert property (@(posedge sys_clk) disable iff (rst)
      !(av_req.read || av_req.write) |-> !av_waitrequest)
      else $error("waitrequest without request");
   a_reset_quiet: assert property (@(posedge sys_clk)
      rst |=> !irq_req && av_readdata == 32'h00000000)
      else $error("outputs not cleared by reset");
   a_rdata_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !(av_req.read && av_waitrequest && clk_en) |=> $stable(av_readdata))
      else $error("read data changed without read");
   a_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
      rd_done |-> av_readdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_bit7_zero: assert property (@(posedge sys_clk) disable iff (rst)
      rd_done && av_req.address inside {8'h04, 8'h08, 8'h0C, 8'h10}
      |-> !av_readdata[7]) else $error("flag bit 7 read as one");
   a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
      rd_done && av_req.address >= 8'hC0 |-> av_readdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_irq_fall_cause: assert property (@(posedge sys_clk)
      disable iff (rst) $fell(irq_req) |-> $past(wr_done) || $past(rst))
      else $error("interrupt dropped without host write");
endmodule // itu_irq_and_timer_unit_checker

bind itu_irq_and_timer_unit itu_irq_and_timer_unit_checker #(
   .FIFO_DEPTH(FIFO_DEPTH), .LEVEL_W(LEVEL_W)) itu_chk_inst (
   .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .av_req(av_req),
   .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
   .irq_req(irq_req));

`default_nettype wire

// *** test_irq_and_timer_unit.sv ***
// Testbench: register sequences against the event and counter unit
`timescale 1ns/1ps
`default_nettype none

module test_irq_and_timer_unit;
   import itu_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   itu_av_req_t av_req;
   logic [31:0] av_readdata;
   logic av_waitrequest;
   itu_events_t events;
   logic [9:0] fifo_level;
   logic [3:0] stop_event;
   logic [2:0] cnt_clk;
   logic clk_en;
   logic irq_req;
   logic [31:0] rd;
   int errors = 0;
   int tests_run = 0;
   itu_events_t ev_tab [6] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200,
                               13'h0100, 13'h0001};
   logic [7:0] ev_reg [6] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h04};
   logic [7:0] ev_exp [6] = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h10, 8'h20};
   always #20 sys_clk = ~sys_clk;
   // -----------------------------------------------------------------
   // Instances
   // -----------------------------------------------------------------
   itu_host_model itu_host_model_inst (.sys_clk(sys_clk), .av_req(av_req),
      .av_readdata(av_readdata), .av_waitrequest(av_waitrequest));
   itu_irq_and_timer_unit #(.FIFO_DEPTH(512), .LEVEL_W(10))
      itu_irq_and_timer_unit_inst (.sys_clk(sys_clk), .rst(rst),
      .clk_en(clk_en), .av_req(av_req), .av_readdata(av_readdata),
      .av_waitrequest(av_waitrequest), .events(events),
      .fifo_level(fifo_level), .stop_event(stop_event),
      .count_clk_fast(cnt_clk[0]), .count_clk_mid(cnt_clk[1]),
      .slow_oscillator(cnt_clk[2]), .irq_req(irq_req));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      itu_host_model_inst.rd(a, rd);
      check(rd, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      itu_host_model_inst.wr(a, d);
   endtask
   // Pin is looked at once the edge that moves it has settled
   task automatic pin(input logic exp);
      @(negedge sys_clk);
      check({31'h00000000, irq_req}, {31'h00000000, exp});
   endtask
   // Count clock pulses long enough for the synchronisers
   task automatic tick(input int sel, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         cnt_clk[sel] <= 1'b1;
         repeat (3) @(posedge sys_clk);
         cnt_clk[sel] <= 1'b0;
         repeat (6) @(posedge sys_clk);
      end
   endtask
   task automatic pulse(input itu_events_t e);
      @(posedge sys_clk);
      events <= e;
      @(posedge sys_clk);
      events <= '0;
      @(negedge sys_clk);
   endtask
   task automatic level(input logic [9:0] v);
      @(posedge sys_clk);
      fifo_level <= v;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic complete_run;
      $display("comparisons %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic fail_wait;
      errors++;
      $display("ERROR %0t: bus wait ran out", $time);
      complete_run();
   endtask
   // -----------------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------------
   initial begin
      events <= '0;
      fifo_level <= 10'h014;
      stop_event <= 4'h0;
      cnt_clk <= 3'h0;
      clk_en <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(ITU_PRIMARY_STATUS_REG, 32'h00000002);
      rchk(ITU_FIFO_THRESHOLD, 32'h00000008);
      rchk(ITU_EVENT_FLAGS_A, 32'h00000000);
      wr(8'hC0, 8'hFF);
      rchk(8'hC0, 32'h00000000);
      wr(ITU_EVENT_ENABLE_A, 8'hFF);
      rchk(ITU_EVENT_ENABLE_A, 32'h0000007F);
      wr(ITU_EVENT_ENABLE_A, 8'h05);
      rchk(ITU_EVENT_ENABLE_A, 32'h0000007A);
      itu_host_model_inst.wr_lanes(ITU_EVENT_ENABLE_A, 8'h85, 4'hE);
      rchk(ITU_EVENT_ENABLE_A, 32'h0000007A);
      wr(ITU_EVENT_ENABLE_A, 8'h7F);
      wr(ITU_EVENT_FLAGS_B, 8'h81);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000001);
      wr(ITU_EVENT_FLAGS_B, 8'h01);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000000);
      for (int i = 0; i < 6; i++) begin
         pulse(ev_tab[i]);
         rchk(ev_reg[i], {24'h000000, ev_exp[i]});
         wr(ev_reg[i], ev_exp[i]);
      end
      wr(ITU_EVENT_ENABLE_A, 8'h81);
      pulse(13'h1000);
      check({31'h00000000, irq_req}, 32'h00000001);
      rchk(ITU_PRIMARY_STATUS_REG, 32'h00000003);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000040);
      wr(ITU_PRIMARY_STATUS_REG, 8'h00);
      pin(1'b0);
      wr(ITU_PRIMARY_STATUS_REG, 8'h02);
      wr(ITU_EVENT_FLAGS_A, 8'h01);
      pin(1'b0);
      wr(ITU_EVENT_FLAGS_B, 8'h40);
      wr(ITU_EVENT_ENABLE_A, 8'h01);
      level(10'h1F7);
      rchk(ITU_EVENT_FLAGS_A, 32'h00000000);
      level(10'h1F8);
      rchk(ITU_EVENT_FLAGS_A, 32'h00000008);
      level(10'h009);
      wr(ITU_EVENT_FLAGS_A, 8'h08);
      level(10'h008);
      rchk(ITU_EVENT_FLAGS_A, 32'h00000010);
      wr(ITU_FIFO_THRESHOLD_MSB, 8'h01);
      wr(ITU_EVENT_FLAGS_A, 8'h10);
      level(10'h0F8);
      rchk(ITU_EVENT_FLAGS_A, 32'h00000008);
      wr(ITU_FIFO_THRESHOLD_MSB, 8'h00);
      wr(ITU_EVENT_FLAGS_A, 8'h08);
      wr(8'h28, 8'h02);
      itu_host_model_inst.start(0);
      rchk(ITU_COUNTER_GROUP_CONTROL, 32'h00000001);
      rchk(8'h30, 32'h00000002);
      tick(0, 2);
      rchk(8'h30, 32'h00000000);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000000);
      tick(0, 1);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000001);
      rchk(ITU_COUNTER_GROUP_CONTROL, 32'h00000000);
      wr(ITU_EVENT_FLAGS_B, 8'h01);
      wr(8'h80, 8'h05);
      wr(8'h88, 8'h01);
      itu_host_model_inst.start(3);
      tick(1, 2);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000008);
      rchk(8'h90, 32'h00000001);
      itu_host_model_inst.stop(3);
      rchk(ITU_COUNTER_GROUP_CONTROL, 32'h00000000);
      wr(ITU_EVENT_FLAGS_B, 8'h08);
      wr(8'h40, 8'h08);
      wr(8'h48, 8'h02);
      itu_host_model_inst.start(1);
      tick(0, 1);
      @(posedge sys_clk);
      stop_event <= 4'h2;
      @(posedge sys_clk);
      stop_event <= 4'h0;
      tick(0, 3);
      rchk(ITU_COUNTER_GROUP_CONTROL, 32'h00000000);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000000);
      rchk(8'h50, 32'h00000001);
      wr(8'h60, 8'h02);
      itu_host_model_inst.start(2);
      wr(8'hA0, 8'h03);
      tick(2, 1);
      rchk(ITU_EVENT_FLAGS_B, 32'h00000024);
      wr(8'hA0, 8'h00);
      itu_host_model_inst.start(0);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      tick(0, 1);
      clk_en <= 1'b1;
      rchk(8'h30, 32'h00000002);
      tick(0, 1);
      rchk(8'h30, 32'h00000001);
      complete_run();
   end
endmodule // test_irq_and_timer_unit

`default_nettype wire
